// ==== rtl/ric_irq_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none
module ric_irq_arbiter #(
   parameter int NSRC = ric_pkg::RIC_NSRC
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic in_reset_i,
   input wire logic instr_end_i,
   input wire logic gmask_i,
   input wire logic swi_i,
   input wire logic ack_i,
   input wire logic [NSRC-1:0] src_i,
   input wire logic [NSRC-1:0] en_i,
   output logic req_o,
   output logic [15:0] vector_o
);
   import ric_pkg::*;
   logic latched_q;
   logic found;
   logic [4:0] win_num;
   wire [NSRC-1:0] pend = src_i & en_i;

   // Lowest index has highest priority
   always_comb
   begin
      found = 1'b0;
      win_num = 5'h00;
      for (int k = NSRC - 1; k >= 0; k--)
      begin
         if (pend[k])
         begin
            found = 1'b1; // [RL19]
            win_num = ric_src_num(k);
         end
      end
   end

   wire take = instr_end_i && !latched_q && (swi_i || (!gmask_i && found)); // [RL18] [RL21]

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         latched_q <= 1'b0;
         req_o <= 1'b0;
         vector_o <= RIC_VEC_RESET;
      end
      else if (in_reset_i)
      begin
         latched_q <= 1'b0;
         req_o <= 1'b0;
         vector_o <= RIC_VEC_RESET; // [RL20]
      end
      else if (take)
      begin
         latched_q <= 1'b1; // [RL16] [RL17]
         req_o <= 1'b1;
         vector_o <= swi_i ? RIC_VEC_SWI : ric_vector(win_num); // [RL20]
      end
      else if (ack_i)
      begin
         latched_q <= 1'b0; // [RL22]
         req_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== rtl/ric_sys_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
module ric_sys_counter #(
   parameter int TICK_CYC = ric_pkg::RIC_TICK_CYC
) (
   input wire logic clk_i,
   input wire logic reset_i,
   ric_cnt_if.counter cnt
);
   import ric_pkg::*;
   localparam logic [12:0] WRAP = 13'(TICK_CYC - 1);
   localparam logic [12:0] FULL = 13'(RIC_LONG_CYC);
   logic [12:0] count_q;
   logic [12:0] count_d;
   logic tick_q;
   logic tick_d;
   wire wrap_hit = !cnt.timing && (count_q >= WRAP);

   always_comb
   begin
      count_d = count_q + 13'h0001;
      tick_d = 1'b0;
      if (cnt.clear)
      begin
         count_d = 13'h0000;
      end
      else if (cnt.service)
      begin
         count_d = {count_q[12], 8'h00, count_q[3:0]}; // [RL3]
      end
      else if (cnt.timing)
      begin
         count_d = (count_q == FULL) ? FULL : count_q + 13'h0001;
      end
      else if (wrap_hit)
      begin
         count_d = 13'h0000; // [RL10]
         tick_d = 1'b1; // [RL4]
      end
   end

   // Counts on the falling edge
   always_ff @(negedge clk_i or posedge reset_i) // [RL11]
   begin
      if (reset_i)
      begin
         count_q <= 13'h0000;
         tick_q <= 1'b0;
      end
      else
      begin
         count_q <= count_d;
         tick_q <= tick_d;
      end
   end

   assign cnt.count = count_q;
   assign cnt.tick = tick_q;
endmodule
`default_nettype wire

// ==== rtl/ric_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RL1 - Watchdog overflow resets and flags watchdog cause
// RL2 - Internal resets drive reset pin low
// RL3 - Service write clears watchdog and stages 12-5
// RL4 - Watchdog clock tick at least every 4080
// RL5 - Break in monitor mode may disable watchdog
// RL6 - Illegal opcode flags cause and resets
// RL7 - Stop with stop disabled is illegal opcode
// RL8 - Unmapped opcode fetch flags and resets
// RL9 - Low voltage: flag, 4096 hold, 64 later
// RL10 - Twelve stages plus wrap stage clock watchdog
// RL11 - System counter advances on falling edge
// RL12 - Stop clears counter, times recovery
// RL13 - Stop recovery 32 or 4096 by select
// RL14 - Pin reset leaves counter; counter free-runs
// RL15 - Power-on gates bus clocks until stable
// RL16 - Requests latched and arbitrated into vector
// RL17 - Latched request cannot be displaced
// RL18 - Interrupt only after instruction, unmasked, enabled
// RL19 - Highest pending first, rest afterwards
// RL20 - Fixed priority with fixed vector addresses
// RL21 - Software interrupt ignores global mask
// RL22 - Entry stacks registers and sets mask; the code only drops the latched request on vector ack
// RL23 - Interrupt status flags mirror pending requests
// RL24 - Cause register read-clears; power-on sets only its flag; the code also sets the flag of any cause in the same cycle
// RL25 - Simultaneous resets record every cause
module ric_top #(
   parameter int NSRC = ric_pkg::RIC_NSRC,
   parameter int WDOG_BITS = ric_pkg::RIC_WDOG_BITS,
   parameter int LONG_CYC = ric_pkg::RIC_LONG_CYC,
   parameter int TICK_CYC = ric_pkg::RIC_TICK_CYC
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [7:0] reg_rdata_o,
   input wire logic power_on_reset_signal_i,
   input wire logic low_voltage_i,
   input wire logic reset_pin_i,
   output logic reset_pin_o,
   output logic reset_pin_oe_n_o,
   input wire logic cpu_fetch_i,
   input wire logic [7:0] cpu_opcode_i,
   input wire logic cpu_addr_unmapped_i,
   input wire logic cpu_stop_i,
   input wire logic cpu_instr_end_i,
   input wire logic cpu_global_mask_i,
   input wire logic cpu_swi_i,
   input wire logic cpu_vector_ack_i,
   input wire logic break_active_i,
   input wire logic monitor_mode_i,
   input wire logic [NSRC-1:0] irq_source_i,
   input wire logic [NSRC-1:0] irq_enable_i,
   output logic internal_reset_o,
   output logic bus_clock_enable_o,
   output logic osc_enable_o,
   output logic stop_mode_o,
   output logic irq_request_o,
   output logic [15:0] irq_vector_o
);
   import ric_pkg::*;
   localparam logic [12:0] LONG_CNT = 13'(LONG_CYC);
   localparam logic [12:0] SHORT_CNT = 13'(RIC_SHORT_CYC);
   localparam logic [5:0] PULL_LAST = 6'(RIC_PULL_CYC - 1);
   localparam logic [5:0] HOLD_LAST = 6'(RIC_HOLD_CYC - 1);

   ric_state_t state_q;
   ric_state_t state_d;
   logic [5:0] phase_q;
   logic [WDOG_BITS-1:0] wdog_q;
   logic [7:0] cause_q;
   logic [7:0] cause_d;
   logic [7:0] cause_set;
   logic [1:0] cfg_q;
   logic brk_q;
   logic srec_short_q;
   logic clear_q;
   logic timing_q;
   logic service_q;
   logic [7:0] rdata_q;
   logic pin_drive_q;
   logic irst_q;
   logic busclk_q;
   logic osc_q;
   logic [23:0] flag_vec;

   ric_cnt_if cnt ();

   ric_sys_counter #(
      .TICK_CYC(TICK_CYC)
   ) u_counter (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .cnt(cnt)
   );

   ric_irq_arbiter #(
      .NSRC(NSRC)
   ) u_arbiter (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .in_reset_i(irst_q),
      .instr_end_i(cpu_instr_end_i && state_q == RIC_ST_RUN),
      .gmask_i(cpu_global_mask_i),
      .swi_i(cpu_swi_i),
      .ack_i(cpu_vector_ack_i),
      .src_i(irq_source_i),
      .en_i(irq_enable_i),
      .req_o(irq_request_o),
      .vector_o(irq_vector_o)
   );

   // Register decode
   wire wr_service = reg_write_i && (reg_addr_i == RIC_ADDR_SERVICE);
   wire wr_cfg = reg_write_i && (reg_addr_i == RIC_ADDR_CFG);
   wire wr_brk = reg_write_i && (reg_addr_i == RIC_ADDR_BRK);
   wire rd_cause = reg_read_i && (reg_addr_i == RIC_ADDR_CAUSE);

   // Source events
   wire in_run = (state_q == RIC_ST_RUN);
   wire stop_en = cfg_q[RIC_CFG_STOP_EN];
   wire short_rec = cfg_q[RIC_CFG_SHORT_REC];
   wire wdog_hold = break_active_i && monitor_mode_i && brk_q; // [RL5]
   wire wdog_run = in_run && !wdog_hold;
   wire wdog_ovf = wdog_run && cnt.tick && (&wdog_q); // [RL1]
   wire illegal_opcode_flag_op = cpu_fetch_i && ric_is_illegal(cpu_opcode_i); // [RL6]
   wire illegal_opcode_flag_stop = cpu_stop_i && !stop_en; // [RL7]
   wire illegal_opcode_flag = in_run && (illegal_opcode_flag_op || illegal_opcode_flag_stop);
   wire illegal_address_flag = in_run && cpu_fetch_i && cpu_addr_unmapped_i; // [RL8]
   wire int_evt = wdog_ovf || illegal_opcode_flag || illegal_address_flag;
   wire pin_low = !reset_pin_i && !pin_drive_q;
   wire wake = (|(irq_source_i & irq_enable_i)) || break_active_i || pin_low;
   wire [12:0] srec_target = srec_short_q ? SHORT_CNT : LONG_CNT;
   wire long_done = (cnt.count >= LONG_CNT);
   wire srec_done = (cnt.count >= srec_target); // [RL13]

   // Reset and stop sequencing
   always_comb
   begin
      state_d = state_q;
      if (power_on_reset_signal_i)
      begin
         state_d = RIC_ST_LONG; // [RL15]
      end
      else if (low_voltage_i)
      begin
         state_d = RIC_ST_LVI; // [RL9]
      end
      else
      begin
         case (state_q)
            RIC_ST_RUN:
            begin
               if (int_evt)
               begin
                  state_d = RIC_ST_PULL; // [RL2]
               end
               else if (pin_low)
               begin
                  state_d = RIC_ST_EXT;
               end
               else if (cpu_stop_i && stop_en)
               begin
                  state_d = RIC_ST_STOP; // [RL12]
               end
            end
            RIC_ST_LVI:
            begin
               state_d = RIC_ST_LONG;
            end
            RIC_ST_LONG:
            begin
               if (long_done)
               begin
                  state_d = RIC_ST_PULL; // [RL9]
               end
            end
            RIC_ST_PULL:
            begin
               if (phase_q == PULL_LAST)
               begin
                  state_d = RIC_ST_HOLD;
               end
            end
            RIC_ST_HOLD:
            begin
               if (phase_q == HOLD_LAST)
               begin
                  state_d = RIC_ST_RUN; // [RL14]
               end
            end
            RIC_ST_EXT:
            begin
               if (reset_pin_i)
               begin
                  state_d = RIC_ST_HOLD;
               end
            end
            RIC_ST_STOP:
            begin
               if (pin_low)
               begin
                  state_d = RIC_ST_EXT;
               end
               else if (wake)
               begin
                  state_d = RIC_ST_SREC; // [RL13]
               end
            end
            RIC_ST_SREC:
            begin
               if (pin_low)
               begin
                  state_d = RIC_ST_EXT;
               end
               else if (srec_done)
               begin
                  state_d = RIC_ST_RUN;
               end
            end
            default:
            begin
               state_d = RIC_ST_RUN;
            end
         endcase
      end
   end

   // Counter control
   wire enter_int = (state_d == RIC_ST_PULL) && (state_q == RIC_ST_RUN);
   wire enter_long = (state_d == RIC_ST_LONG) && (state_q != RIC_ST_LONG);
   wire hold_clear = (state_d == RIC_ST_LVI) || (state_d == RIC_ST_STOP);
   wire clear_d = enter_int || enter_long || hold_clear; // [RL12] [RL14]
   wire timing_d = (state_d == RIC_ST_LONG) || (state_d == RIC_ST_SREC);
   wire drive_d = (state_d == RIC_ST_LVI) || (state_d == RIC_ST_LONG) ||
      (state_d == RIC_ST_PULL); // [RL2] [RL9]
   wire irst_d = (state_d != RIC_ST_RUN) && (state_d != RIC_ST_STOP) &&
      (state_d != RIC_ST_SREC);
   wire busclk_d = (state_d == RIC_ST_RUN); // [RL15]

   // Cause flags, set wins over read clear
   always_comb
   begin
      cause_set = 8'h00;
      cause_set[RIC_CAUSE_POR] = power_on_reset_signal_i;
      cause_set[RIC_CAUSE_PIN] = pin_low; // [RL25]
      cause_set[RIC_CAUSE_WDOG] = wdog_ovf; // [RL1]
      cause_set[RIC_CAUSE_ILLEGAL_OPCODE_FLAG] = illegal_opcode_flag; // [RL6] [RL7]
      cause_set[RIC_CAUSE_ILLEGAL_ADDRESS_FLAG] = illegal_address_flag; // [RL8]
      cause_set[RIC_CAUSE_LVI] = low_voltage_i; // [RL9]
      if (power_on_reset_signal_i)
      begin
         cause_d = cause_set; // [RL24]
      end
      else
      begin
         cause_d = (rd_cause ? 8'h00 : cause_q) | cause_set; // [RL24] [RL25]
      end
   end

   // Interrupt status flags
   always_comb
   begin
      flag_vec = 24'h000000;
      for (int k = 0; k < NSRC; k++)
      begin
         flag_vec[ric_src_num(k)] = irq_source_i[k]; // [RL23]
      end
   end

   wire [7:0] rd_mux =
      (reg_addr_i == RIC_ADDR_CAUSE) ? cause_q :
      (reg_addr_i == RIC_ADDR_INT1) ? {flag_vec[6:1], 2'h0} :
      (reg_addr_i == RIC_ADDR_INT2) ? flag_vec[14:7] :
      (reg_addr_i == RIC_ADDR_INT3) ? flag_vec[22:15] :
      (reg_addr_i == RIC_ADDR_CFG) ? {6'h00, cfg_q} :
      (reg_addr_i == RIC_ADDR_BRK) ? {7'h00, brk_q} :
      8'h00;

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state_q <= RIC_ST_LONG;
         pin_drive_q <= 1'b1;
         irst_q <= 1'b1;
         busclk_q <= 1'b0;
         clear_q <= 1'b1;
         timing_q <= 1'b1;
         osc_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         pin_drive_q <= drive_d;
         irst_q <= irst_d;
         busclk_q <= busclk_d;
         clear_q <= clear_d;
         timing_q <= timing_d;
         osc_q <= 1'b1; // [RL15]
      end
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         phase_q <= 6'h00;
         srec_short_q <= 1'b0;
      end
      else
      begin
         phase_q <= (state_d == state_q) ? phase_q + 6'h01 : 6'h00;
         if (state_q == RIC_ST_STOP && state_d == RIC_ST_SREC)
         begin
            srec_short_q <= short_rec; // [RL13]
         end
      end
   end

   // Watchdog counter
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         wdog_q <= '0;
         service_q <= 1'b0;
      end
      else
      begin
         service_q <= wr_service; // [RL3]
         if (wr_service || !in_run)
         begin
            wdog_q <= '0; // [RL3]
         end
         else if (wdog_run && cnt.tick)
         begin
            wdog_q <= wdog_q + 1'b1; // [RL10]
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         cause_q <= RIC_CAUSE_RESET;
         cfg_q <= RIC_CFG_RESET;
         brk_q <= RIC_BRK_RESET;
         rdata_q <= 8'h00;
      end
      else
      begin
         cause_q <= cause_d;
         rdata_q <= reg_read_i ? rd_mux : 8'h00;
         if (wr_cfg)
         begin
            cfg_q <= reg_wdata_i[1:0];
         end
         if (wr_brk)
         begin
            brk_q <= reg_wdata_i[RIC_BRK_DIS_WDOG];
         end
      end
   end

   assign cnt.clear = clear_q;
   assign cnt.timing = timing_q;
   assign cnt.service = service_q;
   assign reg_rdata_o = rdata_q;
   assign reset_pin_o = 1'b0;
   assign reset_pin_oe_n_o = !pin_drive_q;
   assign internal_reset_o = irst_q;
   assign bus_clock_enable_o = busclk_q;
   assign osc_enable_o = osc_q;
   assign stop_mode_o = !irst_q && !busclk_q;
endmodule
`default_nettype wire

// ==== shared/ric_cnt_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface ric_cnt_if;
   logic clear;
   logic service;
   logic timing;
   logic [12:0] count;
   logic tick;
   modport counter (input clear, input service, input timing, output count, output tick);
   modport ctl (output clear, output service, output timing, input count, input tick);
endinterface
`default_nettype wire

// ==== shared/ric_pkg.sv ====
`default_nettype none
package ric_pkg;
   // Register addresses
   localparam logic [15:0] RIC_ADDR_CAUSE = 16'hFE01;
   localparam logic [15:0] RIC_ADDR_INT1 = 16'hFE04;
   localparam logic [15:0] RIC_ADDR_INT2 = 16'hFE05;
   localparam logic [15:0] RIC_ADDR_INT3 = 16'hFE06;
   localparam logic [15:0] RIC_ADDR_CFG = 16'hFE08;
   localparam logic [15:0] RIC_ADDR_BRK = 16'hFE09;
   localparam logic [15:0] RIC_ADDR_SERVICE = 16'hFFFF;
   // Reset cause bits
   localparam int RIC_CAUSE_POR = 7;
   localparam int RIC_CAUSE_PIN = 6;
   localparam int RIC_CAUSE_WDOG = 5;
   localparam int RIC_CAUSE_ILLEGAL_OPCODE_FLAG = 4;
   localparam int RIC_CAUSE_ILLEGAL_ADDRESS_FLAG = 3;
   localparam int RIC_CAUSE_LVI = 1;
   localparam logic [7:0] RIC_CAUSE_RESET = 8'h80;
   // Control bits
   localparam int RIC_CFG_SHORT_REC = 0;
   localparam int RIC_CFG_STOP_EN = 1;
   localparam int RIC_BRK_DIS_WDOG = 0;
   localparam logic [1:0] RIC_CFG_RESET = 2'h0;
   localparam logic RIC_BRK_RESET = 1'b0;
   // Timing counts
   localparam int RIC_LONG_CYC = 4096;
   localparam int RIC_SHORT_CYC = 32;
   localparam int RIC_PULL_CYC = 32;
   localparam int RIC_HOLD_CYC = 32;
   localparam int RIC_TICK_CYC = 4080;
   localparam int RIC_WDOG_BITS = 6;
   // Interrupt sources and vectors
   localparam int RIC_NSRC = 17;
   localparam logic [15:0] RIC_VEC_RESET = 16'hFFFE;
   localparam logic [15:0] RIC_VEC_SWI = 16'hFFFC;
   localparam logic [15:0] RIC_VEC_BASE = 16'hFFFC;
   // Arbitrary example illegal opcode
   localparam logic [7:0] RIC_ILLEGAL_OP = 8'hAC;

   typedef enum logic [2:0] {
      RIC_ST_RUN = 3'b000,
      RIC_ST_LVI = 3'b001,
      RIC_ST_LONG = 3'b010,
      RIC_ST_PULL = 3'b011,
      RIC_ST_HOLD = 3'b100,
      RIC_ST_STOP = 3'b101,
      RIC_ST_SREC = 3'b110,
      RIC_ST_EXT = 3'b111
   } ric_state_t;

   // Flag number of a source
   function automatic logic [4:0] ric_src_num(input int k);
      if (k == 0)
      begin
         return 5'h01;
      end
      else if (k <= 5)
      begin
         return 5'(k + 2);
      end
      return 5'(k + 3);
   endfunction

   function automatic logic [15:0] ric_vector(input logic [4:0] n);
      return RIC_VEC_BASE - {10'h000, n, 1'b0};
   endfunction

   function automatic logic ric_is_illegal(input logic [7:0] op);
      return op == RIC_ILLEGAL_OP;
   endfunction
endpackage
`default_nettype wire

// ==== test/reset_and_interrupt_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module reset_and_interrupt_control_tb;
   import ric_pkg::*;
   localparam int NS = RIC_NSRC;
   localparam int LONG_C = 64;
   localparam int TICK_C = 40;
   logic clk_i = 1'b0;
   logic reset_i;
   logic [15:0] reg_addr_i = 16'h0000;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_write_i = 1'b0, reg_read_i = 1'b0, power_on_reset_signal_i = 1'b0;
   logic low_voltage_i = 1'b0, ext_n = 1'b1, cpu_fetch_i = 1'b0, cpu_addr_unmapped_i = 1'b0;
   logic [7:0] reg_rdata_o, d;
   logic [7:0] cpu_opcode_i = 8'h00;
   wire reset_pin_i;
   logic cpu_stop_i = 1'b0, cpu_global_mask_i = 1'b0, break_active_i = 1'b1;
   logic monitor_mode_i = 1'b1, go = 1'b0, swi_req = 1'b0, auto = 1'b0, m;
   logic [NS-1:0] irq_source_i = '0, irq_enable_i = '1, p;
   logic reset_pin_o, reset_pin_oe_n_o, cpu_instr_end_i, cpu_swi_i, cpu_vector_ack_i;
   logic internal_reset_o, bus_clock_enable_o, osc_enable_o, stop_mode_o, irq_request_o;
   logic [15:0] irq_vector_o, e;
   logic [3:0] delay = 4'h0;
   logic [23:0] w;
   int mismatches = 0, checked = 0, cyc = 0, n;
   assign reset_pin_i = ext_n & (reset_pin_oe_n_o | reset_pin_o);
   ric_top #(.LONG_CYC(LONG_C), .TICK_CYC(TICK_C), .WDOG_BITS(2)) ric_top_i (.*);
   ric_cpu_model ric_cpu_model_i (.clk_i, .reset_i, .go_i(go), .swi_req_i(swi_req),
      .auto_ack_i(auto), .ack_delay_i(delay), .irq_request_i(irq_request_o),
      .cpu_instr_end_o(cpu_instr_end_i), .cpu_swi_o(cpu_swi_i),
      .cpu_vector_ack_o(cpu_vector_ack_i));
   always #20 clk_i = ~clk_i;
   function automatic int flag_of(input int k);
      return k == 0 ? 1 : (k <= 5 ? k + 2 : k + 3);
   endfunction
   task automatic wrap_up();
      if (mismatches == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_write_i <= 1'b1;
      @(posedge clk_i);
      reg_write_i <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge clk_i);
      reg_read_i <= 1'b0;
      @(negedge clk_i);
      d = reg_rdata_o;
   endtask
   task automatic wait_run();
      for (int i = 0; i < 6000 && bus_clock_enable_o !== 1'b1; i++)
         @(negedge clk_i);
      wr(RIC_ADDR_BRK, 8'h01);
   endtask
   task automatic boundary(input logic s);
      @(posedge clk_i);
      go <= 1'b1;
      swi_req <= s;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (2) @(negedge clk_i);
   endtask
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         mismatches++;
         wrap_up();
      end
   end
   initial
   begin
      reset_i = 1'b1;
      void'($urandom(32'h746CBB85));
      repeat (16) @(posedge clk_i);
      reset_i <= 1'b0;
      wait_run();
      check(bus_clock_enable_o, 1);
      rd(RIC_ADDR_CAUSE);
      check(d, 8'h80);
      rd(RIC_ADDR_CAUSE);
      check(d, 8'h00);
      wr(16'hFE02, 8'hFF);
      wr(RIC_ADDR_INT1, 8'hFF);
      rd(RIC_ADDR_INT1);
      check(d, 8'h00);
      for (int k = 0; k < NS; k++)
      begin
         irq_source_i <= NS'(1) << k;
         boundary(1'b0);
         check(irq_request_o, 1);
         check(irq_vector_o, 16'hFFFC - 16'(2 * flag_of(k)));
         w = 24'(1) << flag_of(k);
         for (int j = 0; j < 3; j++)
         begin
            rd(RIC_ADDR_INT1 + 16'(j));
            check(d, j == 0 ? {w[6:1], 2'b00} : w[8 * j - 1 +: 8]);
         end
         irq_source_i <= '0;
         auto <= 1'b1;
         repeat (8) @(posedge clk_i);
         check(irq_request_o, 0);
         auto <= 1'b0;
      end
      irq_source_i <= NS'(1) << 16;
      boundary(1'b0);
      irq_source_i <= '1;
      boundary(1'b0);
      check(irq_vector_o, 16'hFFD6);
      auto <= 1'b1;
      repeat (8) @(posedge clk_i);
      boundary(1'b0);
      check(irq_vector_o, 16'hFFFA);
      cpu_global_mask_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      boundary(1'b0);
      check(irq_request_o, 0);
      boundary(1'b1);
      check(irq_vector_o, RIC_VEC_SWI);
      repeat (8) @(negedge clk_i);
      repeat (8)
      begin
         p = NS'($urandom);
         w = 24'($urandom);
         m = 1'($urandom);
         @(posedge clk_i);
         irq_source_i <= p;
         irq_enable_i <= NS'(w);
         cpu_global_mask_i <= m;
         delay <= 4'($urandom % 4);
         p = p & NS'(w);
         boundary(1'b0);
         e = 16'h0000;
         for (int k = NS - 1; k >= 0; k--)
            if (p[k])
               e = 16'hFFFC - 16'(2 * flag_of(k));
         check(irq_request_o, !m && p != 0);
         check(irq_request_o ? irq_vector_o : 16'h0000, e & {16{!m}});
         repeat (8) @(negedge clk_i);
      end
      irq_source_i <= '0;
      cpu_global_mask_i <= 1'b0;
      cpu_addr_unmapped_i <= 1'b1;
      @(posedge clk_i);
      cpu_addr_unmapped_i <= 1'b0;
      repeat (20) @(negedge clk_i);
      check(internal_reset_o, 0);
      for (int f = 0; f < 3; f++)
      begin
         @(posedge clk_i);
         cpu_fetch_i <= f < 2;
         cpu_opcode_i <= f == 0 ? RIC_ILLEGAL_OP : 8'h00;
         cpu_addr_unmapped_i <= f == 1;
         cpu_stop_i <= f == 2;
         @(posedge clk_i);
         cpu_fetch_i <= 1'b0;
         cpu_addr_unmapped_i <= 1'b0;
         cpu_stop_i <= 1'b0;
         repeat (4) @(negedge clk_i);
         check(reset_pin_oe_n_o, 0);
         wait_run();
         rd(RIC_ADDR_CAUSE);
         check(d, f == 1 ? 8'h08 : 8'h10);
      end
      break_active_i <= 1'b0;
      repeat (12)
      begin
         repeat (30) @(posedge clk_i);
         wr(RIC_ADDR_SERVICE, 8'($urandom));
      end
      check(internal_reset_o, 0);
      for (n = 0; n < 300 && internal_reset_o !== 1'b1; n++)
         @(negedge clk_i);
      check(n >= 3 * TICK_C - 20 && n <= 5 * TICK_C, 1);
      break_active_i <= 1'b1;
      wait_run();
      rd(RIC_ADDR_CAUSE);
      check(d, 8'h20);
      break_active_i <= 1'b0;
      irq_enable_i <= '1;
      for (int s = 1; s >= 0; s--)
      begin
         wr(RIC_ADDR_CFG, {6'h00, 1'b1, 1'(s)});
         cpu_stop_i <= 1'b1;
         @(posedge clk_i);
         cpu_stop_i <= 1'b0;
         repeat (20) @(negedge clk_i);
         check(stop_mode_o, 1);
         @(posedge clk_i);
         irq_source_i <= NS'(1);
         for (n = 0; n < 6000 && bus_clock_enable_o !== 1'b1; n++)
            @(negedge clk_i);
         check(n >= (s ? 32 : LONG_C) && n <= (s ? 40 : 4200), 1);
         irq_source_i <= '0;
      end
      low_voltage_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      low_voltage_i <= 1'b0;
      for (n = 0; n < 400 && reset_pin_oe_n_o !== 1'b1; n++)
         @(negedge clk_i);
      check(n >= LONG_C + 28 && n <= LONG_C + 36, 1);
      wait_run();
      rd(RIC_ADDR_CAUSE);
      check(d, 8'h02);
      @(posedge clk_i);
      ext_n <= 1'b0;
      cpu_fetch_i <= 1'b1;
      cpu_opcode_i <= RIC_ILLEGAL_OP;
      @(posedge clk_i);
      cpu_fetch_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      ext_n <= 1'b1;
      wait_run();
      rd(RIC_ADDR_CAUSE);
      check(d, 8'h50);
      wrap_up();
   end
endmodule
`default_nettype wire

// ==== test/ric_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ric_cpu_model (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic go_i,
   input wire logic swi_req_i,
   input wire logic auto_ack_i,
   input wire logic [3:0] ack_delay_i,
   input wire logic irq_request_i,
   output logic cpu_instr_end_o,
   output logic cpu_swi_o,
   output logic cpu_vector_ack_o
);
   logic [3:0] wait_q;
   // Boundary pulses and delayed vector fetch
   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         cpu_instr_end_o <= 1'b0;
         cpu_swi_o <= 1'b0;
         cpu_vector_ack_o <= 1'b0;
         wait_q <= 4'h0;
      end
      else
      begin
         cpu_instr_end_o <= go_i;
         cpu_swi_o <= go_i & swi_req_i;
         cpu_vector_ack_o <= 1'b0;
         if (irq_request_i && auto_ack_i && !cpu_vector_ack_o)
         begin
            wait_q <= wait_q + 4'h1;
            if (wait_q >= ack_delay_i)
            begin
               cpu_vector_ack_o <= 1'b1;
               wait_q <= 4'h0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== test/ric_top_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module ric_top_asserts (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic cpu_fetch_i,
   input wire logic [7:0] cpu_opcode_i,
   input wire logic cpu_addr_unmapped_i,
   input wire logic cpu_instr_end_i,
   input wire logic cpu_global_mask_i,
   input wire logic cpu_swi_i,
   input wire logic cpu_vector_ack_i,
   input wire logic reset_pin_oe_n_o,
   input wire logic internal_reset_o,
   input wire logic bus_clock_enable_o,
   input wire logic stop_mode_o,
   input wire logic irq_request_o,
   input wire logic [15:0] irq_vector_o
);
   wire run = bus_clock_enable_o && !internal_reset_o && !stop_mode_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   chk_pin_reset: assert property (!reset_pin_oe_n_o |-> internal_reset_o)
      else $error("pin driven outside reset");
   chk_fault_pull: assert property (
      run && cpu_fetch_i && (cpu_addr_unmapped_i || cpu_opcode_i == ric_pkg::RIC_ILLEGAL_OP)
      |-> ##[1:3] !reset_pin_oe_n_o) else $error("fault left pin free");
   chk_release_gap: assert property (
      $rose(reset_pin_oe_n_o) |-> ##26 internal_reset_o ##[1:12] !internal_reset_o)
      else $error("reset hold length wrong");
   chk_gate_reset: assert property (
      internal_reset_o && $past(internal_reset_o) |-> !bus_clock_enable_o)
      else $error("bus clocks run in reset");
   chk_gate_stop: assert property (
      stop_mode_o && $past(stop_mode_o) |-> !bus_clock_enable_o)
      else $error("bus clocks run in stop");
   chk_reset_vec: assert property (
      internal_reset_o && $past(internal_reset_o) |-> irq_vector_o == ric_pkg::RIC_VEC_RESET)
      else $error("wrong vector in reset");
   chk_latch_hold: assert property (
      irq_request_o && !cpu_vector_ack_i
      |=> internal_reset_o || irq_request_o && $stable(irq_vector_o))
      else $error("latched interrupt displaced");
   chk_ack_drop: assert property (
      irq_request_o && cpu_vector_ack_i |=> !irq_request_o)
      else $error("request kept after fetch");
   chk_mask_gate: assert property (
      !irq_request_o && cpu_instr_end_i && cpu_global_mask_i && !cpu_swi_i |=> !irq_request_o)
      else $error("masked interrupt taken");
   chk_swi_vec: assert property (
      run && !irq_request_o && cpu_instr_end_i && cpu_swi_i
      |=> irq_request_o && irq_vector_o == ric_pkg::RIC_VEC_SWI)
      else $error("software interrupt not taken");
endmodule
bind ric_top ric_top_asserts ric_top_asserts_i (.*);
`default_nettype wire
